// >>> hw/slt_consts.svh
// register offsets, field positions, reset values and timing counts of the stairwell light timer
`ifndef SLT_CONSTS_SVH
`define SLT_CONSTS_SVH

`define SLT_REG_CTRL        8'h00
`define SLT_REG_OFF_DELAY   8'h04
`define SLT_REG_WARN_OFS    8'h08
`define SLT_REG_WARN_LEN    8'h0c
`define SLT_REG_SRC_SEL     8'h10
`define SLT_REG_TICK_DIV    8'h14
`define SLT_REG_STATUS      8'h18
`define SLT_REG_ELAPSED     8'h1c
`define SLT_REG_RET_TIME    8'h20

`define SLT_CTRL_WARN_EN    0
`define SLT_CTRL_RETAIN     1
`define SLT_CTRL_SRC_T      2
`define SLT_CTRL_SRC_W      3
`define SLT_CTRL_SRC_L      4
`define SLT_CTRL_RESTORE    5

`define SLT_RST_OFF_DELAY   32'h0000_000a
`define SLT_RST_WARN_OFS    32'h0000_0003
`define SLT_RST_WARN_LEN    32'h0000_0001
`define SLT_RST_TICK_DIV    32'h0000_9c3f
`define SLT_RST_CTRL        6'h02

`define SLT_TICK_NS         25
`define SLT_BASE_NS         1000000
`define SLT_BASE_CYCLES     (`SLT_BASE_NS / `SLT_TICK_NS)

`endif

// >>> hw/slt_pkg.sv
// types of the stairwell light timer
package slt_pkg;
    typedef enum logic [3:0] {
        SLT_IDLE  = 4'b0001,
        SLT_HOLD  = 4'b0010,
        SLT_RUN   = 4'b0100,
        SLT_WARN  = 4'b1000
    } slt_state_t;

    typedef enum logic [1:0] {
        SLT_AXI_IDLE = 2'b01,
        SLT_AXI_RESP = 2'b10
    } slt_axi_t;
endpackage

// >>> hw/slt_tick_gen.sv
// timebase tick divider for the stairwell light timer
`timescale 1ns/1ps
`default_nettype none
module slt_tick_gen #(
    parameter int W = 32
) (
    input  wire logic         ref_clk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] div,
    output logic              tick
);
    import slt_pkg::*;

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         tick;
    } slt_tick_st_t;

    slt_tick_st_t st_ff;
    slt_tick_st_t nxt_st;

    // one-cycle tick each div+1 clocks; a lowered div takes effect at once
    always_comb begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        if (st_ff.cnt >= div) begin
            nxt_st.cnt = '0;
            nxt_st.tick = 1'b1;
        end else begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tick = st_ff.tick;
endmodule
`default_nettype wire

// >>> hw/slt_timer.sv
// stairwell light timer with axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
`include "slt_consts.svh"

// Functional notes
// R1: a rising trigger edge turns the light on at once.
// R2: the trigger's following falling edge restarts elapsed time from zero, light stays on.
// R3: the light goes off when elapsed time equals the off-delay.
// R4: with warning enabled the light drops when remaining time equals the warning offset, for the warning length.
// R5: the warning offset sets the warning start and a separate length sets its duration.
// R6: any further trigger pulse during the count restarts it from zero.
// R7: with retention the saved level and elapsed time come back at power-up, otherwise defaults.
// R8: software gives all three times the same timebase.
// R9: each time comes from a constant or a live value of another block chosen by block number.
// R10: elapsed time advances once per timebase tick and holds at zero while idle.
module slt_timer #(
    parameter int W      = 32,
    parameter int NSRC   = 8
) (
    input  wire logic              ref_clk,
    input  wire logic              reset_n,
    input  wire logic              trig_in,
    output logic                   light_out,
    input  wire logic [NSRC*W-1:0] src_values,
    input  wire logic              ret_valid,
    input  wire logic              ret_light,
    input  wire logic [W-1:0]      ret_elapsed,
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);
    import slt_pkg::*;

    typedef struct packed {
        logic [1:0]   trig_sync;
        logic         trig_prev;
        slt_state_t   state;
        logic [W-1:0] elapsed_time;
        logic [W-1:0] warn_cnt;
        logic         light;
        logic         restored;
        logic [5:0]   ctrl;
        logic [W-1:0] off_delay;
        logic [W-1:0] warn_ofs;
        logic [W-1:0] warn_len;
        logic [23:0]  src_sel;
        logic [W-1:0] tick_div;
        logic         aw_got;
        logic         w_got;
        logic [7:0]   aw_addr;
        logic [31:0]  w_data;
        logic [3:0]   w_strb;
        logic         bvalid;
        logic [1:0]   bresp;
        logic         rvalid;
        logic [1:0]   rresp;
        logic [31:0]  rdata;
    } slt_st_t;

    slt_st_t      st_ff;
    slt_st_t      nxt_st;
    logic         tick;
    logic [W-1:0] sel_val [3];
    logic [W-1:0] t_off;
    logic [W-1:0] t_wofs;
    logic [W-1:0] t_wlen;

    slt_tick_gen #(.W(W)) u_tick (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .div     (st_ff.tick_div),
        .tick    (tick)
    );

    // live values of other blocks picked by block number, one selector per time R9
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_src
            logic [7:0] num;
            assign num = st_ff.src_sel[g*8 +: 8];
            assign sel_val[g] = (num < 8'(NSRC)) ? src_values[num*W +: W] : '0;
        end
    endgenerate

    // constant or live source per time; all share the one tick, so one timebase R8
    assign t_off  = st_ff.ctrl[`SLT_CTRL_SRC_T] ? sel_val[0] : st_ff.off_delay;
    assign t_wofs = st_ff.ctrl[`SLT_CTRL_SRC_W] ? sel_val[1] : st_ff.warn_ofs;
    assign t_wlen = st_ff.ctrl[`SLT_CTRL_SRC_L] ? sel_val[2] : st_ff.warn_len;

    always_comb begin
        logic rise;
        logic fall;
        logic [W-1:0] nxt_el;
        logic [7:0]   ra;
        logic [31:0]  wmask;
        rise = 1'b0;
        fall = 1'b0;
        nxt_el = '0;
        ra = s_axi_araddr;
        wmask = '0;
        nxt_st = st_ff;

        // trigger sync then edge detect on the second stage only
        nxt_st.trig_sync = {st_ff.trig_sync[0], trig_in};
        nxt_st.trig_prev = st_ff.trig_sync[1];
        rise = st_ff.trig_sync[1] & ~st_ff.trig_prev;
        fall = ~st_ff.trig_sync[1] & st_ff.trig_prev;
        nxt_el = st_ff.elapsed_time + 1'b1;

        // one-shot restore after reset; retention off keeps the reset defaults R7
        if (!st_ff.restored && ret_valid) begin
            nxt_st.restored = 1'b1;
            if (st_ff.ctrl[`SLT_CTRL_RETAIN] && ret_light) begin
                nxt_st.light = 1'b1; // R7
                nxt_st.elapsed_time = ret_elapsed; // R7
                nxt_st.state = SLT_RUN;
            end
        end else begin
            case (st_ff.state)
                SLT_IDLE: begin
                    nxt_st.elapsed_time = '0; // R10
                    if (rise) begin
                        nxt_st.light = 1'b1; // R1
                        nxt_st.state = SLT_HOLD;
                    end
                end
                SLT_HOLD: begin
                    // count waits for the falling edge, light held on
                    if (fall) begin
                        nxt_st.elapsed_time = '0; // R2
                        nxt_st.state = SLT_RUN;
                    end
                end
                SLT_RUN, SLT_WARN: begin
                    if (rise) begin
                        nxt_st.elapsed_time = '0; // R6
                        nxt_st.light = 1'b1;
                        nxt_st.state = SLT_HOLD;
                    end else if (st_ff.elapsed_time >= t_off) begin
                        nxt_st.light = 1'b0; // R3
                        nxt_st.elapsed_time = '0;
                        nxt_st.state = SLT_IDLE;
                    end else if (tick) begin
                        nxt_st.elapsed_time = nxt_el; // R10
                        if (st_ff.state == SLT_WARN) begin
                            nxt_st.warn_cnt = st_ff.warn_cnt + 1'b1;
                            if (st_ff.warn_cnt + 1'b1 >= t_wlen) begin
                                nxt_st.light = 1'b1; // R4
                                nxt_st.state = SLT_RUN;
                            end
                        end else if (st_ff.ctrl[`SLT_CTRL_WARN_EN] && t_wlen != '0 &&
                                     t_off >= t_wofs && nxt_el == t_off - t_wofs && nxt_el < t_off) begin
                            nxt_st.light = 1'b0; // R4 R5
                            nxt_st.warn_cnt = '0;
                            nxt_st.state = SLT_WARN;
                        end
                    end
                end
                default: begin
                    nxt_st.state = SLT_IDLE;
                    nxt_st.light = 1'b0;
                end
            endcase
        end

        // axi write: address and data taken in either order, response after both
        if (s_axi_awvalid && !st_ff.aw_got) begin
            nxt_st.aw_got = 1'b1;
            nxt_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_ff.w_got) begin
            nxt_st.w_got = 1'b1;
            nxt_st.w_data = s_axi_wdata;
            nxt_st.w_strb = s_axi_wstrb;
        end
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end
        if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
            wmask = {{8{st_ff.w_strb[3]}}, {8{st_ff.w_strb[2]}}, {8{st_ff.w_strb[1]}}, {8{st_ff.w_strb[0]}}};
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = 2'b00;
            case ({st_ff.aw_addr[7:2], 2'b00})
                `SLT_REG_CTRL:
                    nxt_st.ctrl = 6'((st_ff.w_data & wmask) | (32'(st_ff.ctrl) & ~wmask));
                `SLT_REG_OFF_DELAY:
                    nxt_st.off_delay = W'((st_ff.w_data & wmask) | (32'(st_ff.off_delay) & ~wmask));
                `SLT_REG_WARN_OFS:
                    nxt_st.warn_ofs = W'((st_ff.w_data & wmask) | (32'(st_ff.warn_ofs) & ~wmask));
                `SLT_REG_WARN_LEN:
                    nxt_st.warn_len = W'((st_ff.w_data & wmask) | (32'(st_ff.warn_len) & ~wmask));
                `SLT_REG_SRC_SEL:
                    nxt_st.src_sel = 24'((st_ff.w_data & wmask) | (32'(st_ff.src_sel) & ~wmask));
                `SLT_REG_TICK_DIV:
                    nxt_st.tick_div = W'((st_ff.w_data & wmask) | (32'(st_ff.tick_div) & ~wmask));
                `SLT_REG_STATUS, `SLT_REG_ELAPSED, `SLT_REG_RET_TIME: ;
                default:
                    nxt_st.bresp = 2'b10; // unmapped gives slverr
            endcase
        end

        // axi read: one read at a time, answer one cycle after the address
        if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !st_ff.rvalid) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp = 2'b00;
            case ({ra[7:2], 2'b00})
                `SLT_REG_CTRL:      nxt_st.rdata = 32'(st_ff.ctrl);
                `SLT_REG_OFF_DELAY: nxt_st.rdata = 32'(st_ff.off_delay);
                `SLT_REG_WARN_OFS:  nxt_st.rdata = 32'(st_ff.warn_ofs);
                `SLT_REG_WARN_LEN:  nxt_st.rdata = 32'(st_ff.warn_len);
                `SLT_REG_SRC_SEL:   nxt_st.rdata = 32'(st_ff.src_sel);
                `SLT_REG_TICK_DIV:  nxt_st.rdata = 32'(st_ff.tick_div);
                `SLT_REG_STATUS:    nxt_st.rdata = {26'h0, st_ff.restored, st_ff.light, st_ff.state};
                `SLT_REG_ELAPSED:   nxt_st.rdata = 32'(st_ff.elapsed_time);
                `SLT_REG_RET_TIME:  nxt_st.rdata = 32'(t_off);
                default: begin
                    nxt_st.rdata = 32'h0;
                    nxt_st.rresp = 2'b10;
                end
            endcase
        end
    end

    // reset defaults; retention comes later through the restore port
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '0;
            st_ff.state <= SLT_IDLE;
            st_ff.off_delay <= W'(`SLT_RST_OFF_DELAY);
            st_ff.warn_ofs <= W'(`SLT_RST_WARN_OFS);
            st_ff.warn_len <= W'(`SLT_RST_WARN_LEN);
            st_ff.tick_div <= W'(`SLT_RST_TICK_DIV);
            st_ff.ctrl <= `SLT_RST_CTRL;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign light_out     = st_ff.light;
    assign s_axi_awready = !st_ff.aw_got;
    assign s_axi_wready  = !st_ff.w_got;
    assign s_axi_bvalid  = st_ff.bvalid;
    assign s_axi_bresp   = st_ff.bresp;
    assign s_axi_arready = !st_ff.rvalid;
    assign s_axi_rvalid  = st_ff.rvalid;
    assign s_axi_rdata   = st_ff.rdata;
    assign s_axi_rresp   = st_ff.rresp;
endmodule
`default_nettype wire

// >>> verification/slt_partner.sv
// push-button source and lamp load on the far side of the timer
`timescale 1ns/1ps
`default_nettype none
module slt_partner (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        press,
    input  wire logic [7:0]  hold_len,
    input  wire logic        light_out,
    output logic             trig_in,
    output logic [15:0]      lit_cycles
);
    logic [7:0] left_ff;
    // button held hold_len cycles; shorter presses are stretched so the sync sees them
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            trig_in <= 1'b0;
            left_ff <= 8'h00;
        end else if (press) begin
            trig_in <= 1'b1;
            left_ff <= (hold_len < 8'h02) ? 8'h01 : hold_len - 8'h01;
        end else if (left_ff != 8'h00) begin
            left_ff <= left_ff - 8'h01;
        end else begin
            trig_in <= 1'b0;
        end
    end
    // lamp meter: lit cycles since switched on from dark; a retrigger keeps the count
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n)
            lit_cycles <= 16'h0000;
        else if (press && !light_out)
            lit_cycles <= 16'h0000;
        else if (light_out)
            lit_cycles <= lit_cycles + 16'h0001;
    end
endmodule
`default_nettype wire

// >>> verification/slt_timer_asserts.sv
// port-level assertions of the stairwell light timer
`timescale 1ns/1ps
`default_nettype none
module slt_timer_asserts (
    input wire logic        ref_clk,
    input wire logic        reset_n,
    input wire logic        trig_in,
    input wire logic        light_out,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // handshake steps, one edge each
    sequence s_aw; s_axi_awvalid && s_axi_awready; endsequence
    sequence s_both; s_aw ##0 (s_axi_wvalid && s_axi_wready); endsequence
    sequence s_ar; s_axi_arvalid && s_axi_arready; endsequence
    // two sync flops plus the output flop bound the light latency
    chk_light_rise: assert property ($rose(trig_in) |-> ##[1:4] light_out)
        else $error("light did not follow trigger rise");
    chk_light_held: assert property (trig_in [*5] |-> light_out)
        else $error("light low while trigger held");
    chk_aw_refused: assert property (s_aw |=> !s_axi_awready)
        else $error("write address accepted twice");
    // response is issued on the edge after both are held, so it is seen one edge later
    chk_b_follows: assert property ((s_both ##1 !s_axi_bvalid) |=> s_axi_bvalid)
        else $error("write response late");
    chk_b_clears: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not cleared");
    chk_r_follows: assert property (s_ar |=> s_axi_rvalid)
        else $error("read data late");
    chk_r_clears: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data not cleared");
    chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address open while data pending");
endmodule
bind slt_timer slt_timer_asserts i_slt_timer_asserts (.ref_clk, .reset_n, .trig_in, .light_out,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// >>> verification/slt_timer_bench.sv
// self-checking bench of the stairwell light timer
`timescale 1ns/1ps
`default_nettype none
`include "slt_consts.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
    $display("CHECK FAILED %0t %h %h", $time, a, b); end end
module slt_timer_bench;
    logic        ref_clk = 0, reset_n = 0, press = 0, ret_valid = 0, ret_light = 0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        trig_in, light_out, awready, wready, bvalid, arready, rvalid;
    logic [31:0] ret_elapsed = 0, wdata = 0, rdata, rdat, seed = 32'ha408;
    logic [255:0] src = 0, tsrc;
    logic [7:0]  awaddr = 0, araddr = 0, hold = 2;
    logic [2:0]  n;
    logic [1:0]  bresp, rresp, resp;
    logic [3:0]  strb = 4'hf;
    logic [15:0] lit, l, l0, k, h, d;
    logic [7:0]  ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18, 8'h1c, 8'h20};
    logic [31:0] rv [8] = '{32'h2, `SLT_RST_OFF_DELAY, `SLT_RST_WARN_OFS, `SLT_RST_WARN_LEN, 32'h0,
                            32'h21, 32'h0, `SLT_RST_OFF_DELAY};
    int          bad_count = 0, compares = 0;
    slt_timer i_slt_timer (.ref_clk, .reset_n, .trig_in, .light_out, .src_values(src), .ret_valid,
        .ret_light, .ret_elapsed, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    slt_partner i_slt_partner (.ref_clk, .reset_n, .press, .hold_len(hold), .light_out, .trig_in,
        .lit_cycles(lit));
    initial forever #12.5 ref_clk = ~ref_clk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // aw and w offered together, each dropped at its own take edge
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        bit pa, pw;
        pa = 1;
        pw = 1;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (pa || pw) begin
            @(posedge ref_clk);
            pa = pa && (awready !== 1'b1);
            pw = pw && (wready !== 1'b1);
            awvalid <= pa;
            wvalid <= pw;
        end
        do @(posedge ref_clk); while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(posedge ref_clk); while (arready !== 1'b1);
        arvalid <= 0;
        do @(posedge ref_clk); while (rvalid !== 1'b1);
        rdat = rdata;
        resp = rresp;
        rready <= 0;
        @(posedge ref_clk);
    endtask
    // lamp counted as done after eight dark cycles, longer than any warning drop
    task automatic settle;
        int q;
        q = 0;
        while (q < 8) begin
            @(posedge ref_clk);
            q = (light_out === 1'b0 && trig_in === 1'b0) ? q + 1 : 0;
        end
        l = lit;
    endtask
    task automatic run(input logic [15:0] hl, input int gap);
        hold <= hl[7:0];
        press <= 1;
        @(posedge ref_clk);
        press <= 0;
        if (gap > 0) begin
            repeat (gap - 1) @(posedge ref_clk);
            press <= 1;
            @(posedge ref_clk);
            press <= 0;
        end
        settle();
    endtask
    // retained level and time are offered only once the tick is fast
    task automatic rst(input logic rl, input logic [31:0] re, input logic keep);
        reset_n <= 0;
        ret_valid <= 0;
        ret_light <= rl;
        ret_elapsed <= re;
        repeat (6) @(posedge ref_clk);
        reset_n <= 1;
        @(posedge ref_clk);
        rd(`SLT_REG_TICK_DIV);
        `CHK(rdat, `SLT_RST_TICK_DIV)
        wr(`SLT_REG_TICK_DIV, 32'h0);
        // clearing retention before the restore is offered must keep the defaults
        if (!keep)
            wr(`SLT_REG_CTRL, 32'h0);
        ret_valid <= 1;
    endtask
    task automatic summarize;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // watchdog sized well above the under one thousand cycles the tests need
    initial begin
        repeat (40000) @(posedge ref_clk);
        bad_count++;
        summarize();
    end
    initial begin
        rst(1'b0, 32'h0, 1'b1);
        repeat (20) @(posedge ref_clk);
        `CHK(light_out, 1'b0)
        foreach (ra[i]) begin
            rd(ra[i]);
            `CHK(rdat, rv[i])
        end
        rd(8'h24);
        `CHK({resp, rdat}, {2'b10, 32'h0})
        wr(8'h28, 32'h5);
        `CHK(resp, 2'b10)
        // only the low byte lane lands
        strb <= 4'h1;
        wr(`SLT_REG_OFF_DELAY, 32'hffff_ff07);
        strb <= 4'hf;
        rd(`SLT_REG_OFF_DELAY);
        `CHK(rdat, 32'h7)
        $display("test registers done");
        wr(`SLT_REG_OFF_DELAY, 32'd20);
        run(16'd3, 0);
        l0 = l;
        // lit cycles are hold + delay + 1: the off check lands an edge after the tick reaching the delay
        k = 16'd1;
        `CHK(l, 16'd24)
        repeat (4) begin
            seed = lfsr(seed);
            h = 16'd2 + seed[1:0];
            d = 16'd8 + seed[11:4];
            wr(`SLT_REG_OFF_DELAY, {16'h0, d});
            run(h, 0);
            `CHK(l - h - d, k)
        end
        $display("test off delay done");
        wr(`SLT_REG_OFF_DELAY, 32'd20);
        run(16'd3, 9);
        `CHK(l - l0, 16'd9)
        wr(`SLT_REG_CTRL, 32'h3);
        wr(`SLT_REG_WARN_OFS, 32'd5);
        for (int wl = 1; wl <= 3; wl += 2) begin
            wr(`SLT_REG_WARN_LEN, wl);
            run(16'd3, 0);
            `CHK(l0 - l, wl[15:0])
        end
        $display("test retrigger and warning done");
        seed = lfsr(seed);
        n = seed[2:0];
        d = 16'd6 + seed[7:3];
        tsrc = {8{lfsr(seed)}};
        tsrc[{n, 5'h00}+:32] = {16'h0, d};
        src <= tsrc;
        wr(`SLT_REG_SRC_SEL, {29'h0, n});
        wr(`SLT_REG_CTRL, 32'h6);
        wr(`SLT_REG_OFF_DELAY, 32'd3);
        rd(`SLT_REG_RET_TIME);
        `CHK(rdat, {16'h0, d})
        run(16'd5, 0);
        `CHK(l - 16'd5 - d, k)
        $display("test live source done");
        for (int e = 2; e <= 6; e += 4) begin
            rst(1'b1, e, 1'b1);
            settle();
            if (e == 2)
                l0 = l;
        end
        `CHK(l0 - l, 16'd4)
        `CHK(l0 > 16'd4, 1'b1)
        rst(1'b1, 32'd2, 1'b0);
        settle();
        `CHK(l, 16'd0)
        $display("test retention done");
        summarize();
    end
endmodule
`default_nettype wire
